// ---- rtl/scan_timing_pkg.sv ----
// Purpose : constants and carrier types for the linear sensor scan timing block
// Assumes : ref_clk_i at 50 MHz, sensor clock and start pulse arrive from the controller
// Notes   : one scan is 88 dummy strobes followed by 4096 pixel strobes
package scan_timing_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ       = 50_000_000;
    localparam int unsigned REF_PERIOD_NS    = 1_000_000_000 / REF_CLK_HZ;
    localparam int unsigned SENSOR_MIN_NS    = 100;
    localparam int unsigned SENSOR_MIN_CYC   = (SENSOR_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam logic [7:0]  SENSOR_MIN_CNT   = 8'(SENSOR_MIN_CYC);

    // ------------------------------------------------------------------
    // scan geometry
    // ------------------------------------------------------------------
    localparam int unsigned PIXEL_COUNT      = 4096;
    localparam int unsigned FIRST_PIXEL_STRB = 89;
    localparam int unsigned INTEG_TAIL       = 48;
    localparam int unsigned LEVEL_W          = 12;
    localparam int unsigned ADDR_W           = 12;
    localparam int unsigned SLOT_W           = 13;
    localparam logic [SLOT_W-1:0] FIRST_PIXEL_SLOT = SLOT_W'(FIRST_PIXEL_STRB - 1);
    localparam logic [SLOT_W-1:0] LAST_SLOT        = SLOT_W'(FIRST_PIXEL_STRB - 2 + PIXEL_COUNT);
    localparam logic [5:0]        INTEG_TAIL_CNT   = 6'(INTEG_TAIL);
    localparam logic [ADDR_W-1:0] ADDR_RESET       = 12'h000;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET     = 12'h000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic               pixel;
        logic               last;
        logic [LEVEL_W-1:0] level;
    } pix_word_t;

    typedef enum logic {
        SCAN_IDLE,
        SCAN_READ
    } scan_state_t;

endpackage : scan_timing_pkg

// ---- rtl/pix_buffer.sv ----
// Purpose : two-entry buffer between the pixel shifter and the video output
// Assumes : single clock, synchronous active-high reset
// Notes   : in_ready_o low only when both entries hold words
`timescale 1ns/100ps
module pix_buffer (
    input  wire logic                        ref_clk_i,
    input  wire logic                        sys_rst_i,
    input  wire logic                        in_valid_i,
    output      logic                        in_ready_o,
    input  wire scan_timing_pkg::pix_word_t  in_data_i,
    output      logic                        out_valid_o,
    input  wire logic                        out_ready_i,
    output      scan_timing_pkg::pix_word_t  out_data_o
);
    import scan_timing_pkg::*;

    pix_word_t  mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + 2'(push) - 2'(pop);
        end
    end

endmodule : pix_buffer

// ---- rtl/linear_sensor_scan_timing.sv ----
// Purpose : scan timing generator of a linear image sensor, driven by clock and start pulse, strobes held back by video_ready_i
// Assumes : controller keeps start pulse timing and clock duty within limits
// Notes   : pixel levels are read from the photosite array through pixel_addr_o
//
// Functional notes
// - Pixel value is stable when the sampling strobe rises.
// - Shifting starts on first clock rise after start pulse falls.
// - Integration lasts start pulse high time plus 48 clocks.
// - First valid pixel comes with the 89th strobe after start falls.
// - Each scan reads out 4096 pixels in order.
// - One pixel per clock; clock must not exceed 10 MHz.
`timescale 1ns/100ps
module linear_sensor_scan_timing (
    input  wire logic                                      ref_clk_i,
    input  wire logic                                      sys_rst_i,
    input  wire logic                                      sensor_clk_i,
    input  wire logic                                      scan_start_pulse_i,
    input  wire logic [scan_timing_pkg::LEVEL_W-1:0]       pixel_level_i,
    input  wire logic                                      video_ready_i,
    output      logic [scan_timing_pkg::LEVEL_W-1:0]       video_o,
    output      logic                                      pixel_valid_o,
    output      logic                                      strobe_o,
    output      logic                                      scan_done_output_o,
    output      logic [scan_timing_pkg::ADDR_W-1:0]        pixel_addr_o,
    output      logic                                      integrating_o,
    output      logic                                      overrate_o
);
    import scan_timing_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] clk_sync;
    logic [2:0] st_sync;
    logic       clk_acc;
    logic       st_acc;

    // a change counts once the second and third stages agree
    wire next_clk_acc = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_acc;
    wire next_st_acc  = (st_sync[1] == st_sync[2]) ? st_sync[2] : st_acc;
    wire clk_rise     = next_clk_acc & ~clk_acc;
    wire st_rise      = next_st_acc & ~st_acc;
    wire st_fall      = ~next_st_acc & st_acc;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            clk_sync <= 3'h0;
            st_sync  <= 3'h0;
            clk_acc  <= 1'b0;
            st_acc   <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[1:0], sensor_clk_i};
            st_sync  <= {st_sync[1:0], scan_start_pulse_i};
            clk_acc  <= next_clk_acc;
            st_acc   <= next_st_acc;
        end
    end

    // ------------------------------------------------------------------
    // clock rate watch
    // ------------------------------------------------------------------
    logic [7:0] period_cnt;
    logic       clk_seen;

    wire too_fast = clk_rise & clk_seen & (period_cnt < SENSOR_MIN_CNT);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            period_cnt <= 8'h00;
            clk_seen   <= 1'b0;
            overrate_o <= 1'b0;
        end else begin
            if (clk_rise) begin
                period_cnt <= 8'h01;
                clk_seen   <= 1'b1;
            end else if (period_cnt != 8'hFF) begin
                period_cnt <= period_cnt + 8'h01;
            end
            // sticky: pixels may be lost above the rate, software must know
            if (too_fast) begin
                overrate_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // integration window
    // ------------------------------------------------------------------
    logic [5:0] tail_cnt;
    logic       tail_run;

    wire tail_end = tail_run & clk_rise & (tail_cnt == INTEG_TAIL_CNT - 6'h01);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            integrating_o <= 1'b0;
            tail_run      <= 1'b0;
            tail_cnt      <= 6'h00;
        end else if (st_rise) begin
            integrating_o <= 1'b1;
            tail_run      <= 1'b0;
        end else if (st_fall) begin
            tail_run <= 1'b1;
            tail_cnt <= 6'h00;
        end else if (tail_end) begin
            integrating_o <= 1'b0;
            tail_run      <= 1'b0;
        end else if (tail_run & clk_rise) begin
            tail_cnt <= tail_cnt + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // shift sequencer
    // ------------------------------------------------------------------
    scan_state_t       state;
    scan_state_t       next_state;
    logic [SLOT_W-1:0] slot;
    logic              pending;
    logic              buf_in_ready;
    pix_word_t         push_word;

    wire reading    = (state == SCAN_READ);
    wire slot_req   = reading & (clk_rise | pending);
    wire push       = slot_req & buf_in_ready;
    wire is_pixel   = (slot >= FIRST_PIXEL_SLOT);
    wire is_last    = (slot == LAST_SLOT);

    // one driver for the whole word; dummy slots carry a zero level
    assign push_word = '{pixel: is_pixel, last: is_last, level: (is_pixel ? pixel_level_i : LEVEL_RESET)};

    always_comb begin
        next_state = state;
        case (state)
            SCAN_IDLE: begin
                if (st_fall) begin
                    next_state = SCAN_READ;
                end
            end
            SCAN_READ: begin
                if (push & is_last & ~st_fall) begin
                    next_state = SCAN_IDLE;
                end
            end
            default: begin
                next_state = SCAN_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state        <= SCAN_IDLE;
            slot         <= '0;
            pending      <= 1'b0;
            pixel_addr_o <= ADDR_RESET;
        end else begin
            state <= next_state;
            // a new start fall abandons any line still shifting
            if (st_fall) begin
                slot         <= '0;
                pending      <= 1'b0;
                pixel_addr_o <= ADDR_RESET;
            end else if (push) begin
                slot    <= slot + SLOT_W'(1);
                pending <= 1'b0;
                if (is_pixel) begin
                    pixel_addr_o <= pixel_addr_o + ADDR_W'(1);
                end
            end else if (slot_req) begin
                // stall: hold the shift until the buffer frees an entry
                pending <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // output buffer and video drive
    // ------------------------------------------------------------------
    logic      buf_out_valid;
    pix_word_t buf_out_data;
    logic      buf_last_q;

    // strobe is one cycle wide, so words leave at most every other cycle
    wire pop = buf_out_valid & video_ready_i & ~strobe_o;

    pix_buffer u_pix_buffer (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (push_word),
        .out_valid_o (buf_out_valid),
        .out_ready_i (pop),
        .out_data_o  (buf_out_data)
    );

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            video_o            <= LEVEL_RESET;
            pixel_valid_o      <= 1'b0;
            strobe_o           <= 1'b0;
            scan_done_output_o <= 1'b0;
        end else begin
            strobe_o           <= pop;
            scan_done_output_o <= strobe_o & pixel_valid_o & buf_last_q;
            if (pop) begin
                video_o       <= buf_out_data.level;
                pixel_valid_o <= buf_out_data.pixel;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            buf_last_q <= 1'b0;
        end else if (pop) begin
            buf_last_q <= buf_out_data.last;
        end
    end

endmodule : linear_sensor_scan_timing

// ---- test/scan_timing_monitor.sv ----
// Purpose: port checker for the scan timing block
// Assumes: one clock domain, synchronous reset
// Notes: pin sync delay is allowed up to six edges
`timescale 1ns/100ps
module scan_timing_monitor (
    input wire logic                                ref_clk_i,
    input wire logic                                sys_rst_i,
    input wire logic                                sensor_clk_i,
    input wire logic                                scan_start_pulse_i,
    input wire logic [scan_timing_pkg::LEVEL_W-1:0] pixel_level_i,
    input wire logic                                video_ready_i,
    input wire logic [scan_timing_pkg::LEVEL_W-1:0] video_o,
    input wire logic                                pixel_valid_o,
    input wire logic                                strobe_o,
    input wire logic                                scan_done_output_o,
    input wire logic [scan_timing_pkg::ADDR_W-1:0]  pixel_addr_o,
    input wire logic                                integrating_o,
    input wire logic                                overrate_o
);
    import scan_timing_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_start_fall;
        $fell(scan_start_pulse_i);
    endsequence
    sequence s_last_strobe;
        $past(strobe_o) && $past(pixel_valid_o);
    endsequence
    a_strobe_single: assert property (strobe_o |=> !strobe_o)
        else $error("strobe longer than one cycle");
    a_video_stable: assert property (!strobe_o |-> $stable(video_o) && $stable(pixel_valid_o))
        else $error("video changed without strobe");
    a_dummy_zero: assert property (strobe_o && !pixel_valid_o |-> video_o == LEVEL_RESET)
        else $error("dummy slot carries a level");
    a_done_pulse: assert property (scan_done_output_o |=> !scan_done_output_o)
        else $error("scan done longer than one cycle");
    a_done_last: assert property (scan_done_output_o |-> s_last_strobe)
        else $error("scan done not after a pixel strobe");
    a_fall_addr: assert property (s_start_fall |-> ##[1:6] pixel_addr_o == ADDR_RESET)
        else $error("start fall did not restart the line");
    a_integ_rise: assert property ($rose(scan_start_pulse_i) |-> ##[1:6] integrating_o)
        else $error("integration did not start");
    a_integ_hold: assert property (integrating_o && scan_start_pulse_i |=> integrating_o)
        else $error("integration ended while start high");
    a_overrate_keep: assert property (overrate_o |=> overrate_o)
        else $error("overrate flag dropped");
endmodule : scan_timing_monitor
bind linear_sensor_scan_timing scan_timing_monitor u_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .sensor_clk_i(sensor_clk_i), .scan_start_pulse_i(scan_start_pulse_i), .pixel_level_i(pixel_level_i),
    .video_ready_i(video_ready_i), .video_o(video_o), .pixel_valid_o(pixel_valid_o), .strobe_o(strobe_o),
    .scan_done_output_o(scan_done_output_o), .pixel_addr_o(pixel_addr_o), .integrating_o(integrating_o),
    .overrate_o(overrate_o));

// ---- test/sensor_ctrl_model.sv ----
// Purpose: controller model, drives sensor clock and start pulse, captures pixels
// Assumes: tasks start just after a falling ref edge
// Notes: sensor clock stands low between frames
`timescale 1ns/100ps
module sensor_ctrl_model (
    input  wire logic                                ref_clk_i,
    input  wire logic                                strobe_i,
    input  wire logic                                pixel_valid_i,
    input  wire logic [scan_timing_pkg::LEVEL_W-1:0] video_i,
    input  wire logic                                scan_done_i,
    output      logic                                sensor_clk_o,
    output      logic                                scan_start_pulse_o
);
    import scan_timing_pkg::*;
    int n_strb, n_pix, first_pix, n_done, bad;
    initial begin
        sensor_clk_o = 1'b0;
        scan_start_pulse_o = 1'b0;
    end
    task automatic clocks(input int n, input int half_ns);
        repeat (n) begin
            #(half_ns) sensor_clk_o = 1'b1;
            #(half_ns) sensor_clk_o = 1'b0;
        end
    endtask : clocks
    task automatic scan(input int hi, input int n, input int half_ns);
        scan_start_pulse_o = 1'b1;
        clocks(hi, half_ns);
        scan_start_pulse_o = 1'b0;
        fork
            clocks(n, half_ns);
            begin
                #100; // strobes of an aborted line drain first, clear lands off the ref rising edge
                {n_strb, n_pix, first_pix, n_done, bad} = '0;
            end
        join
    endtask : scan
    always @(posedge ref_clk_i) begin
        if (strobe_i === 1'b1) begin
            n_strb++;
            if (pixel_valid_i === 1'b1) begin
                if (n_pix == 0) first_pix = n_strb;
                if (video_i !== (LEVEL_W'(n_pix) ^ 12'h5A5)) bad++;
                n_pix++;
            end
        end
        if (scan_done_i === 1'b1) begin
            n_done++;
            if (n_pix != PIXEL_COUNT) bad++;
        end
    end
endmodule : sensor_ctrl_model

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the scan timing block
// Assumes: sensor clock 120 ns period (80 ns in the overrate test), edges away from ref rising edges
// Notes: pixel level is a pattern of its address
`timescale 1ns/100ps
module tb_top;
    import scan_timing_pkg::*;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, video_ready_i = 1'b1;
    logic sensor_clk_i, scan_start_pulse_i, strobe_o, pixel_valid_o, scan_done_output_o, integrating_o, overrate_o;
    logic [LEVEL_W-1:0] video_o, pixel_level_i;
    logic [ADDR_W-1:0]  pixel_addr_o;
    int failures = 0, cmp_count = 0, integ_cyc = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    assign pixel_level_i = pixel_addr_o ^ 12'h5A5;
    always @(posedge ref_clk_i) if (integrating_o === 1'b1) integ_cyc <= integ_cyc + 1;
    linear_sensor_scan_timing dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sensor_clk_i(sensor_clk_i),
        .scan_start_pulse_i(scan_start_pulse_i), .pixel_level_i(pixel_level_i), .video_ready_i(video_ready_i),
        .video_o(video_o), .pixel_valid_o(pixel_valid_o), .strobe_o(strobe_o), .scan_done_output_o(scan_done_output_o),
        .pixel_addr_o(pixel_addr_o), .integrating_o(integrating_o), .overrate_o(overrate_o));
    sensor_ctrl_model u_ctrl (.ref_clk_i(ref_clk_i), .strobe_i(strobe_o), .pixel_valid_i(pixel_valid_o),
        .video_i(video_o), .scan_done_i(scan_done_output_o), .sensor_clk_o(sensor_clk_i),
        .scan_start_pulse_o(scan_start_pulse_i));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic judge_line(input int hi);
        int d;
        repeat (20) @(negedge ref_clk_i);
        d = integ_cyc - ((hi + INTEG_TAIL) * 6 - 3);
        check(u_ctrl.n_strb, FIRST_PIXEL_STRB - 1 + PIXEL_COUNT);
        check(u_ctrl.first_pix, FIRST_PIXEL_STRB);
        check(u_ctrl.n_pix, PIXEL_COUNT);
        check(u_ctrl.bad, 0);
        check(u_ctrl.n_done, 1);
        check(d >= -2 && d <= 2, 1);
    endtask : judge_line
    task automatic scan_basic();
        integ_cyc = 0;
        u_ctrl.scan(6, 4184, 60);
        judge_line(6);
    endtask : scan_basic
    task automatic scan_restart_stall();
        u_ctrl.scan(6, 300, 60);
        integ_cyc = 0;
        fork
            u_ctrl.scan(40, 4184, 60);
            repeat (80) begin
                repeat (40) @(negedge ref_clk_i);
                video_ready_i = 1'b0; // long enough to fill the buffer
                repeat (13) @(negedge ref_clk_i);
                video_ready_i = 1'b1;
            end
        join
        judge_line(40);
    endtask : scan_restart_stall
    task automatic scan_overrate();
        check(overrate_o, 1'b0);
        u_ctrl.scan(6, 20, 40);
        repeat (10) @(negedge ref_clk_i);
        check(overrate_o, 1'b1);
    endtask : scan_overrate
    task automatic results();
        $display("comparisons %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (90000) @(posedge ref_clk_i);
        failures++;
        results();
    end
    initial begin
        repeat (6) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        scan_basic();
        scan_restart_stall();
        scan_overrate();
        results();
    end
endmodule : tb_top
